/* dcs_regs.vh */
`ifndef DCS_REGS_VH
`define DCS_REGS_VH

// ==========================================================================
// Register map (8-bit address, 16-bit data)
`define DCS_ADDR_CSR        8'h9A
`define DCS_ADDR_INT_STATUS 8'hA0
`define DCS_ADDR_INT_ENABLE 8'hA2
`define DCS_ADDR_INT_CLEAR  8'hA4

// ==========================================================================
// Configuration register fields
`define DCS_CSR_RESET       16'h0000
`define DCS_BIT_TRANS       15
`define DCS_QUAL_HI         14
`define DCS_QUAL_LO         12
`define DCS_BIT_SPARE       9
`define DCS_FAIL_HI         8
`define DCS_FAIL_LO         7
`define DCS_BIT_SYM         4
`define DCS_STATE_HI        3
`define DCS_STATE_LO        0

// ==========================================================================
// Idle transition qualifier codes
`define DCS_QUAL_STAY       3'h0
`define DCS_QUAL_SINGLE_A   3'h1
`define DCS_QUAL_SINGLE_B   3'h2
`define DCS_QUAL_DUAL       3'h3
`define DCS_QUAL_SPARED_D   3'h4
`define DCS_QUAL_SPARED_A   3'h5
`define DCS_QUAL_SPARED_B   3'h6
`define DCS_QUAL_INIT_READ  3'h7

// ==========================================================================
// Reported state codes: [3:2] channel arrangement, [1:0] phase
`define DCS_ST_IDLE         4'h0
`define DCS_ST_INIT_READ    4'h2
`define DCS_ST_A_NORMAL     4'h4
`define DCS_ST_B_NORMAL     4'h8
`define DCS_ST_D_NORMAL     4'hC
`define DCS_ST_A_DONE       4'h7
`define DCS_ST_B_DONE       4'hB
`define DCS_ST_D_DONE       4'hF
`define DCS_PH_NORMAL       2'h0
`define DCS_PH_COPY         2'h1
`define DCS_PH_DONE         2'h3
`define DCS_CH_A            2'h1
`define DCS_CH_B            2'h2
`define DCS_CH_DUAL         2'h3

// ==========================================================================
// Interrupt events
`define DCS_NUM_EVENTS      3
`define DCS_EV_STATE        0
`define DCS_EV_COPY_START   1
`define DCS_EV_COPY_DONE    2

`endif

/* dcs_irq.v */
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Sticky event status, enable mask and level interrupt
module dcs_irq #(
   parameter N = 3
) (
   // Clock and reset
   input  wire         clock,
   input  wire         arst_n,
   // Events, one-cycle pulses
   input  wire [N-1:0] event_in,
   // Software access
   input  wire         clear_wr,
   input  wire [N-1:0] clear_data,
   input  wire         enable_wr,
   input  wire [N-1:0] enable_data,
   // State
   output reg  [N-1:0] status_reg,
   output reg  [N-1:0] enable_reg,
   output reg          irq_reg
);

   wire [N-1:0] status_next;

   genvar i;
   generate
      for (i = 0; i < N; i = i + 1) begin : g_bit
         // A new event beats a clear in the same cycle
         assign status_next[i] = event_in[i] |
            (status_reg[i] & ~(clear_wr & clear_data[i]));
      end
   endgenerate

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         status_reg <= {N{1'b0}};
         enable_reg <= {N{1'b0}};
         irq_reg    <= 1'b0;
      end else begin
         status_reg <= status_next;
         if (enable_wr) begin
            enable_reg <= enable_data;
         end
         irq_reg <= |(status_reg & enable_reg);
      end
   end

endmodule // dcs_irq

`default_nettype wire

/* dcs_copy_ctl.v */
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Launch and tracking of one sparing copy
module dcs_copy_ctl (
   // Clock and reset
   input  wire       clock,
   input  wire       arst_n,
   // From the configuration machine
   input  wire       launch,
   input  wire [1:0] src_pair,
   // From the copy datapath
   input  wire       copy_done,
   // To datapath and machine
   output reg        copy_start_reg,
   output reg  [1:0] copy_src_reg,
   output reg        busy_reg,
   output reg        done_reg
);

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         copy_start_reg <= 1'b0;
         copy_src_reg   <= 2'h0;
         busy_reg       <= 1'b0;
         done_reg       <= 1'b0;
      end else begin
         copy_start_reg <= launch & ~busy_reg;
         done_reg       <= 1'b0;
         if (launch && !busy_reg) begin
            // Source is frozen for the whole copy
            copy_src_reg <= src_pair;
            busy_reg     <= 1'b1;
         end else if (busy_reg && copy_done && !copy_start_reg) begin
            // A done seen in the cycle the start pulse is out is stale
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
         end
      end
   end

endmodule // dcs_copy_ctl

`default_nettype wire

/* dcs_channel_config.v */
`timescale 1ns/1ns
`default_nettype none

`include "dcs_regs.vh"

// ==========================================================================
// Channel configuration machine with its control/status register
module dcs_channel_config (
   // Clock and reset
   input  wire        clock,
   input  wire        arst_n,
   // Register port
   input  wire [7:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   // DRAM rank detection
   input  wire        four_equal_ranks,
   // Copy datapath
   input  wire        copy_done,
   output wire        copy_start,
   output wire [1:0]  copy_src_pair,
   // Decode and channel controls
   output reg         sparing_en,
   output reg         symmetric_decode_en,
   output reg         interleave_en,
   output reg         channel_a_en,
   output reg         channel_b_en,
   output reg         lockstep_en,
   // Interrupt
   output wire        irq
);

   // =======================================================================
   // Register fields
   reg        trans_en_reg;
   reg        trans_en_next;
   reg  [2:0] qual_reg;
   reg        spare_reg;
   reg  [1:0] fail_reg;
   reg        sym_reg;
   reg  [3:0] state_reg;
   reg  [3:0] state_next;

   // =======================================================================
   // Address decode
   wire csr_sel   = (reg_addr == `DCS_ADDR_CSR);
   wire ist_sel   = (reg_addr == `DCS_ADDR_INT_STATUS);
   wire ien_sel   = (reg_addr == `DCS_ADDR_INT_ENABLE);
   wire icl_sel   = (reg_addr == `DCS_ADDR_INT_CLEAR);
   wire csr_wr    = reg_wr & csr_sel;
   wire trans_set = csr_wr & reg_wdata[`DCS_BIT_TRANS];

   // =======================================================================
   // Submodule links
   wire       launch;
   wire       copy_busy;
   wire       copy_fin;
   wire [`DCS_NUM_EVENTS-1:0] events;
   wire [`DCS_NUM_EVENTS-1:0] int_status;
   wire [`DCS_NUM_EVENTS-1:0] int_enable;

   // =======================================================================
   // Machine decode helpers
   wire [1:0] st_ch    = state_reg[3:2];
   wire [1:0] st_ph    = state_reg[1:0];
   wire       st_idle  = (state_reg == `DCS_ST_IDLE) ||
                         (state_reg == `DCS_ST_INIT_READ);
   wire       changed  = (state_next != state_reg);

   // =======================================================================
   // Next state
   always @* begin
      state_next = state_reg;
      if (st_idle) begin
         if (trans_en_reg) begin
            case (qual_reg)
               `DCS_QUAL_STAY:      state_next = `DCS_ST_IDLE;
               `DCS_QUAL_SINGLE_A:  state_next = `DCS_ST_A_NORMAL;
               `DCS_QUAL_SINGLE_B:  state_next = `DCS_ST_B_NORMAL;
               `DCS_QUAL_DUAL:      state_next = `DCS_ST_D_NORMAL;
               // Resume paths skip the copy entirely
               `DCS_QUAL_SPARED_D:  state_next = `DCS_ST_D_DONE;
               `DCS_QUAL_SPARED_A:  state_next = `DCS_ST_A_DONE;
               `DCS_QUAL_SPARED_B:  state_next = `DCS_ST_B_DONE;
               `DCS_QUAL_INIT_READ: state_next = `DCS_ST_INIT_READ;
               default:             state_next = state_reg;
            endcase
         end
      end else begin
         case (st_ph)
            `DCS_PH_NORMAL: begin
               if (trans_en_reg) begin
                  // Copy only with sparing on and the enable set
                  if (spare_reg) begin
                     state_next = {st_ch, `DCS_PH_COPY};
                  end else if (qual_reg == `DCS_QUAL_STAY) begin
                     state_next = `DCS_ST_IDLE;
                  end
               end
            end
            `DCS_PH_COPY: begin
               if (copy_fin) begin
                  state_next = {st_ch, `DCS_PH_DONE};
               end
            end
            `DCS_PH_DONE: begin
               if (trans_en_reg && (qual_reg == `DCS_QUAL_STAY)) begin
                  state_next = `DCS_ST_IDLE;
               end
            end
            default: begin
               // Unused phase codes fall back to idle
               state_next = `DCS_ST_IDLE;
            end
         endcase
      end
   end

   // Copy is launched on the edge that enters the copy phase
   assign launch = (st_ph == `DCS_PH_NORMAL) && !st_idle &&
                   (state_next[1:0] == `DCS_PH_COPY);

   // =======================================================================
   // Transition enable: hardware clears, software only sets
   always @* begin
      trans_en_next = trans_en_reg;
      if (changed) begin
         trans_en_next = 1'b0;
      end
      // A fresh set in the clearing cycle is kept
      if (trans_set) begin
         trans_en_next = 1'b1;
      end
   end

   // =======================================================================
   // Register and machine state
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         trans_en_reg <= 1'b0;
         qual_reg     <= 3'h0;
         spare_reg    <= 1'b0;
         fail_reg     <= 2'h0;
         state_reg    <= `DCS_ST_IDLE;
      end else begin
         trans_en_reg <= trans_en_next;
         state_reg    <= state_next;
         if (csr_wr) begin
            // Read-only fields and reserved bits are not stored
            qual_reg  <= reg_wdata[`DCS_QUAL_HI:`DCS_QUAL_LO];
            spare_reg <= reg_wdata[`DCS_BIT_SPARE];
            fail_reg  <= reg_wdata[`DCS_FAIL_HI:`DCS_FAIL_LO];
         end
      end
   end

   // =======================================================================
   // Decode mode and channel outputs
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sym_reg             <= 1'b0;
         sparing_en          <= 1'b0;
         symmetric_decode_en <= 1'b0;
         interleave_en       <= 1'b0;
         channel_a_en        <= 1'b0;
         channel_b_en        <= 1'b0;
         lockstep_en         <= 1'b0;
      end else begin
         // Interleave only without sparing and with four equal ranks
         sym_reg             <= ~(~spare_reg & four_equal_ranks);
         interleave_en       <= ~spare_reg & four_equal_ranks;
         sparing_en          <= spare_reg;
         symmetric_decode_en <= ~spare_reg;
         channel_a_en        <= (state_next[3:2] == `DCS_CH_A) ||
                                (state_next[3:2] == `DCS_CH_DUAL);
         channel_b_en        <= (state_next[3:2] == `DCS_CH_B) ||
                                (state_next[3:2] == `DCS_CH_DUAL);
         lockstep_en         <= (state_next[3:2] == `DCS_CH_DUAL);
      end
   end

   // =======================================================================
   // Copy launch
   dcs_copy_ctl u_copy (
      .clock          (clock),
      .arst_n         (arst_n),
      .launch         (launch),
      .src_pair       (fail_reg),
      .copy_done      (copy_done),
      .copy_start_reg (copy_start),
      .copy_src_reg   (copy_src_pair),
      .busy_reg       (copy_busy),
      .done_reg       (copy_fin)
   );

   // =======================================================================
   // Interrupts
   assign events[`DCS_EV_STATE]      = changed;
   assign events[`DCS_EV_COPY_START] = launch;
   assign events[`DCS_EV_COPY_DONE]  = copy_fin;

   dcs_irq #(
      .N (`DCS_NUM_EVENTS)
   ) u_irq (
      .clock       (clock),
      .arst_n      (arst_n),
      .event_in    (events),
      .clear_wr    (reg_wr & icl_sel),
      .clear_data  (reg_wdata[`DCS_NUM_EVENTS-1:0]),
      .enable_wr   (reg_wr & ien_sel),
      .enable_data (reg_wdata[`DCS_NUM_EVENTS-1:0]),
      .status_reg  (int_status),
      .enable_reg  (int_enable),
      .irq_reg     (irq)
   );

   // =======================================================================
   // Read data, valid only in the cycle after the read strobe
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= 16'h0000;
         if (reg_rd) begin
            if (csr_sel) begin
               // Init read state shows as idle
               reg_rdata <= {trans_en_reg, qual_reg, 2'h0, spare_reg,
                             fail_reg, 2'h0, sym_reg,
                             st_idle ? `DCS_ST_IDLE : state_reg};
            end else if (ist_sel) begin
               reg_rdata <= {13'h0000, int_status};
            end else if (ien_sel) begin
               reg_rdata <= {13'h0000, int_enable};
            end
         end
      end
   end

   // Codes 1010 and 1110 have no path into state_reg

endmodule // dcs_channel_config

`default_nettype wire

/* dcs_props.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dcs_regs.vh"
// ==========================================================================
// Port checker for the channel configuration block
module dcs_props (
   // Clock and reset
   input wire logic        clock,
   input wire logic        arst_n,
   // Register port
   input wire logic [7:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   // Datapath and controls
   input wire logic        four_equal_ranks,
   input wire logic        copy_start,
   input wire logic [1:0]  copy_src_pair,
   input wire logic        sparing_en,
   input wire logic        symmetric_decode_en,
   input wire logic        interleave_en,
   input wire logic        channel_a_en,
   input wire logic        channel_b_en,
   input wire logic        lockstep_en,
   input wire logic        irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   reset_clear_a: assert property (!$past(arst_n) |-> reg_rdata == 16'h0000
      && !sparing_en && !lockstep_en && !irq) else $error("not clear after reset");
   spare_sym_a: assert property ($past(arst_n) |->
      sparing_en != symmetric_decode_en) else $error("decode modes clash");
   interleave_on_a: assert property ((!sparing_en && four_equal_ranks)[*3]
      |-> interleave_en) else $error("interleave missing");
   lockstep_both_a: assert property (lockstep_en |-> channel_a_en
      && channel_b_en) else $error("lockstep without both channels");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside read cycle");
   csr_fields_a: assert property ($past(reg_rd) &&
      $past(reg_addr) == `DCS_ADDR_CSR |-> reg_rdata[11:10] == 2'h0 &&
      reg_rdata[6:5] == 2'h0 && reg_rdata[3:0] != 4'hA &&
      reg_rdata[3:0] != 4'hE) else $error("bad field in config read");
   start_pulse_a: assert property (copy_start |=> !copy_start
      && $stable(copy_src_pair)) else $error("copy start not a pulse");
   start_spare_a: assert property (copy_start |-> sparing_en)
      else $error("copy without sparing");
   irq_mask_a: assert property (reg_wr && reg_addr == `DCS_ADDR_INT_ENABLE
      && reg_wdata[2:0] == 3'h0 |-> ##[1:2] !irq) else $error("irq not masked");
   copy_c: cover property (copy_start);
   irq_c: cover property ($rose(irq));
   lock_c: cover property (lockstep_en);
endmodule // dcs_props

bind dcs_channel_config dcs_props i_dcs_props (.clock(clock),
   .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .four_equal_ranks(four_equal_ranks), .copy_start(copy_start),
   .copy_src_pair(copy_src_pair), .sparing_en(sparing_en),
   .symmetric_decode_en(symmetric_decode_en),
   .interleave_en(interleave_en), .channel_a_en(channel_a_en),
   .channel_b_en(channel_b_en), .lockstep_en(lockstep_en), .irq(irq));
`default_nettype wire

/* dcs_copy_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Copy datapath stand-in: finishes a copy after a chosen delay
module dcs_copy_model (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       arst_n,
   // From the block
   input  wire logic       copy_start,
   input  wire logic [3:0] delay,
   // Back to the block
   output var  logic       copy_done
);
   logic [3:0] count_reg;
   // Delay must be at least one, zero would never finish
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         count_reg <= 4'h0;
         copy_done <= 1'b0;
      end else begin
         copy_done <= count_reg == 4'h1;
         if (copy_start)
            count_reg <= delay;
         else if (count_reg != 4'h0)
            count_reg <= count_reg - 4'h1;
      end
   end
endmodule // dcs_copy_model
`default_nettype wire

/* tb_dcs_channel_config.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dcs_regs.vh"
module tb_dcs_channel_config;
   logic        clock = 1'b0;
   logic        arst_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        four_equal_ranks = 1'b1;
   logic [3:0]  delay = 4'h1;
   wire  [15:0] reg_rdata;
   wire  [1:0]  copy_src_pair;
   wire         copy_done, copy_start, sparing_en, symmetric_decode_en;
   wire         interleave_en, channel_a_en, channel_b_en, lockstep_en, irq;
   integer      seed = 22047;
   integer      miscompares = 0;
   integer      compares = 0;
   integer      q, i;
   logic [15:0] rv, ev;
   logic [3:0]  s;
   logic [1:0]  f;
   logic [3:0]  st_tab [8] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'hF, 4'h7, 4'hB, 4'h0};

   always #2 clock = ~clock;

   dcs_channel_config i_dcs_channel_config (.clock(clock), .arst_n(arst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .four_equal_ranks(four_equal_ranks), .copy_done(copy_done),
      .copy_start(copy_start), .copy_src_pair(copy_src_pair),
      .sparing_en(sparing_en), .symmetric_decode_en(symmetric_decode_en),
      .interleave_en(interleave_en), .channel_a_en(channel_a_en),
      .channel_b_en(channel_b_en), .lockstep_en(lockstep_en), .irq(irq));
   dcs_copy_model i_dcs_copy_model (.clock(clock), .arst_n(arst_n),
      .copy_start(copy_start), .delay(delay), .copy_done(copy_done));

   function automatic logic [15:0] csr(input logic t, input logic [2:0] qq,
      input logic sp, input logic [1:0] ff, input logic y, input logic [3:0] ss);
      csr = {t, qq, 2'b00, sp, ff, 2'b00, y, ss};
   endfunction

   task automatic wrap_up;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask

   task automatic do_reset;
      @(posedge clock);
      arst_n <= 1'b0;
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
   endtask

   initial begin
      do_reset;
      rd(`DCS_ADDR_CSR);
      chk(rv, 16'h0000);
      wr(8'h55, 16'hFFFF);
      rd(8'h55);
      chk(rv, 16'h0000);
      $display("test reset done");
      // Every qualifier code from idle, rank detection drawn at random
      for (q = 0; q < 8; q = q + 1) begin
         do_reset;
         rv = $random(seed);
         four_equal_ranks <= rv[0];
         wr(`DCS_ADDR_CSR, csr(1'b1, q[2:0], 1'b0, 2'b00, 1'b0, 4'h0));
         repeat (2) @(posedge clock);
         rd(`DCS_ADDR_CSR);
         s = st_tab[q];
         ev = csr(q == 0, q[2:0], 1'b0, 2'b00, !four_equal_ranks, s);
         // Whether init read drops the pending bit is left open
         chk(rv & (q == 7 ? 16'h7FFF : 16'hFFFF), ev);
         chk({13'h0, channel_a_en, channel_b_en, lockstep_en},
             {13'h0, s[2], s[3], s[3] & s[2]});
         chk({13'h0, sparing_en, symmetric_decode_en, interleave_en},
             {14'h1, four_equal_ranks});
      end
      $display("test qualifiers done");
      // Sparing copy in each arrangement, random pair and copy time
      for (q = 1; q < 4; q = q + 1) begin
         do_reset;
         rv = $random(seed);
         f = rv[1:0];
         delay <= 4'h1 + {1'b0, rv[4:2]};
         s = st_tab[q];
         wr(`DCS_ADDR_INT_ENABLE, 16'h0007);
         wr(`DCS_ADDR_CSR, csr(1'b1, q[2:0], 1'b1, f, 1'b0, 4'h0));
         wr(`DCS_ADDR_CSR, csr(1'b0, 3'h0, 1'b1, f, 1'b0, 4'h0));
         for (i = 0; i < 6; i = i + 1) begin
            @(posedge clock);
            #1 chk({15'h0, copy_start}, 16'h0000);
         end
         wr(`DCS_ADDR_CSR, csr(1'b1, 3'h0, 1'b1, f, 1'b0, 4'h0));
         i = 0;
         while (copy_start !== 1'b1 && i < 30) begin
            @(posedge clock);
            #1 i = i + 1;
         end
         if (i == 30) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: copy start never seen", $time);
            wrap_up;
         end
         chk({14'h0, copy_src_pair}, {14'h0, f});
         rd(`DCS_ADDR_CSR);
         chk(rv, csr(1'b0, 3'h0, 1'b1, f, 1'b1, s | 4'h1));
         repeat (16) @(posedge clock);
         wr(`DCS_ADDR_CSR, csr(1'b0, 3'h0, 1'b1, f, 1'b0, 4'h0) | 16'h0C7F);
         rd(`DCS_ADDR_CSR);
         chk(rv, csr(1'b0, 3'h0, 1'b1, f, 1'b1, s | 4'h3));
         chk({13'h0, sparing_en, symmetric_decode_en, interleave_en},
             16'h0004);
         chk({15'h0, irq}, 16'h0001);
         rd(`DCS_ADDR_INT_STATUS);
         chk(rv, 16'h0007);
         wr(`DCS_ADDR_INT_ENABLE, 16'h0000);
         repeat (2) @(posedge clock);
         #1 chk({15'h0, irq}, 16'h0000);
         wr(`DCS_ADDR_INT_CLEAR, 16'h0007);
         rd(`DCS_ADDR_INT_STATUS);
         chk(rv, 16'h0000);
         rd(`DCS_ADDR_INT_CLEAR);
         chk(rv, 16'h0000);
         wr(`DCS_ADDR_CSR, csr(1'b1, 3'h0, 1'b0, 2'b00, 1'b0, 4'h0));
         repeat (2) @(posedge clock);
         rd(`DCS_ADDR_CSR);
         chk(rv, csr(1'b0, 3'h0, 1'b0, 2'b00, !four_equal_ranks, 4'h0));
         $display("test sparing %0d done", q);
      end
      wrap_up;
   end
endmodule // tb_dcs_channel_config
`default_nettype wire
